//--- design/pms_defs.vh
`ifndef PMS_DEFS_VH
`define PMS_DEFS_VH
// Register offsets
`define PMS_REG_CTRL 8'h00
`define PMS_REG_STATUS 8'h04
`define PMS_REG_BW 8'h08
`define PMS_REG_INSEL 8'h0c
`define PMS_REG_PLAN 8'h10
`define PMS_REG_STORE 8'h14
// Control fields
`define PMS_CTRL_HARD 0
`define PMS_CTRL_SOFT 1
`define PMS_CTRL_FAST 2
// Status fields
`define PMS_ST_MODE_LO 0
`define PMS_ST_LOCK 3
`define PMS_ST_INIT 4
`define PMS_ST_HIST 5
// Mode codes
`define PMS_MODE_FREE 3'h0
`define PMS_MODE_FREEZE 3'h1
`define PMS_MODE_ACQ 3'h2
`define PMS_MODE_LOCKED 3'h3
`define PMS_MODE_HOLD 3'h4
// Bandwidth codes: 0 = 20 Hz .. 15 = 4 kHz
`define PMS_BW_MIN 4'h0
`define PMS_BW_MAX 4'hf
`define PMS_BW_RST 8'h3c
// Memory depth and timing
`define PMS_MEM_WORDS 8
`define PMS_HIST_S 120
`define PMS_CLK_HZ 125000000
`define PMS_LOCK_NS 1000
`endif

//--- design/pms_mem.v
`default_nettype none
module pms_mem #(
    parameter AW = 3,
    parameter DW = 32
) (
    // Clock
    input wire clk,
    // Write port
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    // Registered read port
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge clk)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

//--- design/pms_insel.v
`default_nettype none
module pms_insel (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire auto_en,
    input wire revertive,
    input wire [1:0] manual_sel,
    input wire [3:0] valid,
    // Result
    output reg [1:0] sel_q,
    output wire sel_valid
);
    // Lowest index has highest priority
    function [1:0] first_valid;
        input [3:0] v;
        begin
            first_valid = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
        end
    endfunction
    reg [1:0] sel_d;
    assign sel_valid = valid[sel_q];
    always @*
    begin
        sel_d = sel_q;
        if (!auto_en)
            sel_d = manual_sel;
        else if (|valid && (revertive || !valid[sel_q]))
            sel_d = first_valid(valid);
    end
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sel_q <= 2'h0;
        else
            sel_q <= sel_d;
    end
endmodule
`default_nettype wire

//--- design/pms_top.v
// Operation
// - After power-up, load registers and configuration from config memory first.
// - Serial register access is refused until initialization is finished.
// - Output clocks stay off until initialization is complete.
// - Hard reset reloads all registers from memory and restarts everything.
// - Hard reset comes from the reset pin or the hard-reset control bit.
// - Soft reset skips memory download, only applies pending configuration; code also drops init_done for a cycle.
// - After init the loop is in one of five modes.
// - Initialization done enters free-run, output from reference clock only.
// - Free-run is kept while no input clock is valid.
// - Any valid input starts lock acquisition automatically.
// - Fast bandwidth during acquisition when enabled, normal bandwidth afterwards.
// - Normal loop bandwidth register selects 20 Hz to 4 kHz.
// - Fast acquisition bandwidth register selects 20 Hz to 4 kHz.
// - Outputs keep running while the oscillator pulls toward the input.
// - Lock is reported on the loss-of-lock pin and a status bit.
// - Frequency plan is writable and storable to config memory.
// - Active input chosen manually or by the automatic selector.
// - Input lost with valid history enters holdover; history spans 120 s.
// - Input lost without history enters oscillator freeze mode.
// - Holdover or freeze returns to acquisition when an input is valid.
//
// Chosen here: the register addresses and strobed register access.
`include "pms_defs.vh"
`default_nettype none
module pms_top #(
    // Sized product: the history window in clocks does not fit 32 bits
    parameter [63:0] HIST_CYCLES = 64'h1 * `PMS_HIST_S * `PMS_CLK_HZ,
    parameter LOCK_CYCLES = `PMS_LOCK_NS / 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire REF_CLK,
    input wire RESET_N,
    input wire HARD_RESET_PIN_N,
    // Input clock qualification and phase detector
    input wire [3:0] CLK_VALID,
    input wire PHASE_LOCKED,
    // Register port
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    // Status and loop control
    output wire LOCK_LOSS_INDICATOR,
    output wire OUT_CLK_EN,
    output wire INIT_DONE,
    output wire [2:0] MODE,
    output wire [3:0] ACTIVE_BW,
    output wire [1:0] ACTIVE_INPUT,
    output wire [31:0] PLAN
);
    localparam [4:0] S_RESET = 5'h01;
    localparam [4:0] S_LOAD = 5'h02;
    localparam [4:0] S_RUN = 5'h04;
    localparam [4:0] S_STORE = 5'h08;
    localparam [4:0] S_SOFT = 5'h10;
    localparam [AW-1:0] LAST = {AW{1'b1}};
    localparam [63:0] HIST_W = HIST_CYCLES;
    localparam [31:0] LOCK_W = LOCK_CYCLES;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    reg [1:0] pin_sync_q;
    reg [3:0] val_s1_q;
    reg [3:0] val_s2_q;
    reg lk_s1_q;
    reg lk_s2_q;
    always @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            // Idle level of the pin, so release brings no false hard reset
            pin_sync_q <= 2'h3;
            val_s1_q <= 4'h0;
            val_s2_q <= 4'h0;
            lk_s1_q <= 1'b0;
            lk_s2_q <= 1'b0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[0], HARD_RESET_PIN_N};
            val_s1_q <= CLK_VALID;
            val_s2_q <= val_s1_q;
            lk_s1_q <= PHASE_LOCKED;
            lk_s2_q <= lk_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencing
    reg [4:0] st_q;
    reg [4:0] st_d;
    reg [AW-1:0] idx_q;
    reg hard_req_q;
    reg soft_req_q;
    reg store_req_q;
    wire hard_rst = !pin_sync_q[1] || hard_req_q;
    wire init_done = (st_q == S_RUN) || (st_q == S_STORE);
    assign INIT_DONE = init_done;
    assign OUT_CLK_EN = init_done;
    wire bus_ok = (st_q == S_RUN);
    wire wr_ok = WR && bus_ok;
    wire rd_ok = RD && bus_ok;

    // Config memory; word 0 is the frequency plan, 1 bandwidths, 2 input select
    wire [31:0] mem_rdata;
    wire [31:0] plan_live;
    pms_mem #(.AW(AW), .DW(32)) u_mem (
        .clk(REF_CLK),
        .we(st_q == S_STORE),
        .waddr(idx_q),
        .wdata(plan_live),
        .raddr(idx_q),
        .rdata(mem_rdata)
    );

    always @*
    begin
        st_d = st_q;
        case (st_q)
            S_RESET: st_d = S_LOAD;
            S_LOAD: if (idx_q == LAST) st_d = S_RUN;
            S_RUN:
                if (store_req_q)
                    st_d = S_STORE;
                else if (soft_req_q)
                    st_d = S_SOFT;
            S_STORE: if (idx_q == LAST) st_d = S_RUN;
            S_SOFT: st_d = S_RUN;
            default: st_d = S_RESET;
        endcase
        if (hard_rst)
            st_d = S_RESET;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg [31:0] plan_q;
    reg [31:0] plan_pend_q;
    reg [7:0] bw_q;
    reg [7:0] bw_pend_q;
    reg [3:0] insel_q;
    reg [3:0] insel_pend_q;
    reg fast_en_q;
    reg load_ph_q;
    reg [AW-1:0] lidx_q;
    assign plan_live = (idx_q == 0) ? plan_q :
                       (idx_q == 1) ? {24'h0, bw_q} : {28'h0, insel_q};
    assign PLAN = plan_q;

    function [3:0] clamp_bw;
        input [3:0] c;
        begin
            clamp_bw = (c > `PMS_BW_MAX) ? `PMS_BW_MAX : c;
        end
    endfunction

    always @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            st_q <= S_RESET;
            idx_q <= {AW{1'b0}};
            hard_req_q <= 1'b0;
            soft_req_q <= 1'b0;
            store_req_q <= 1'b0;
            plan_q <= 32'h0;
            plan_pend_q <= 32'h0;
            bw_q <= `PMS_BW_RST;
            bw_pend_q <= `PMS_BW_RST;
            insel_q <= 4'h0;
            insel_pend_q <= 4'h0;
            fast_en_q <= 1'b0;
            load_ph_q <= 1'b0;
            lidx_q <= {AW{1'b0}};
        end
        else
        begin
            st_q <= st_d;
            hard_req_q <= wr_ok && (ADDR == `PMS_REG_CTRL) && WDATA[`PMS_CTRL_HARD];
            idx_q <= (st_q == S_LOAD || st_q == S_STORE) ? idx_q + 1'b1 : {AW{1'b0}};
            // Read data lag the address by one cycle; apply it on the next edge
            load_ph_q <= (st_q == S_LOAD);
            lidx_q <= idx_q;
            if (load_ph_q)
            begin
                case (lidx_q)
                    0: begin plan_q <= mem_rdata; plan_pend_q <= mem_rdata; end
                    1: begin bw_q <= mem_rdata[7:0]; bw_pend_q <= mem_rdata[7:0]; end
                    2: begin insel_q <= mem_rdata[3:0]; insel_pend_q <= mem_rdata[3:0]; end
                    default: ;
                endcase
            end
            if (st_q == S_SOFT)
            begin
                plan_q <= plan_pend_q;
                bw_q <= bw_pend_q;
                insel_q <= insel_pend_q;
            end
            if (st_q == S_SOFT || st_q == S_RESET)
                soft_req_q <= 1'b0;
            else if (wr_ok && ADDR == `PMS_REG_CTRL && WDATA[`PMS_CTRL_SOFT])
                soft_req_q <= 1'b1;
            if (st_q == S_STORE || st_q == S_RESET)
                store_req_q <= 1'b0;
            else if (wr_ok && ADDR == `PMS_REG_STORE && WDATA[0])
                store_req_q <= 1'b1;
            if (wr_ok)
            begin
                case (ADDR)
                    `PMS_REG_CTRL: fast_en_q <= WDATA[`PMS_CTRL_FAST];
                    `PMS_REG_BW:
                        bw_pend_q <= {clamp_bw(WDATA[7:4]), clamp_bw(WDATA[3:0])};
                    `PMS_REG_INSEL: insel_pend_q <= WDATA[3:0];
                    `PMS_REG_PLAN: plan_pend_q <= WDATA;
                    default: ;
                endcase
            end
            else if (st_q == S_RESET)
                fast_en_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input selection
    wire sel_valid;
    // Hard reset parks the selector on input 0, as after power-up
    wire sel_clr = (st_q == S_RESET);
    pms_insel u_sel (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .auto_en(insel_q[2] && !sel_clr),
        .revertive(insel_q[3]),
        .manual_sel(sel_clr ? 2'h0 : insel_q[1:0]),
        .valid(val_s2_q),
        .sel_q(ACTIVE_INPUT),
        .sel_valid(sel_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // Loop mode controller
    reg [2:0] mode_q;
    reg [2:0] mode_d;
    reg [31:0] lock_cnt_q;
    reg [63:0] hist_cnt_q;
    wire hist_valid = (hist_cnt_q != 64'h0);
    wire any_valid = |val_s2_q;
    always @*
    begin
        mode_d = mode_q;
        case (mode_q)
            `PMS_MODE_FREE: if (any_valid) mode_d = `PMS_MODE_ACQ;
            `PMS_MODE_ACQ:
                if (!any_valid)
                    mode_d = hist_valid ? `PMS_MODE_HOLD : `PMS_MODE_FREEZE;
                else if (lock_cnt_q >= LOCK_W)
                    mode_d = `PMS_MODE_LOCKED;
            `PMS_MODE_LOCKED:
                if (!any_valid)
                    mode_d = hist_valid ? `PMS_MODE_HOLD : `PMS_MODE_FREEZE;
                else if (!sel_valid || !lk_s2_q)
                    mode_d = `PMS_MODE_ACQ;
            `PMS_MODE_HOLD, `PMS_MODE_FREEZE:
                if (any_valid) mode_d = `PMS_MODE_ACQ;
            default: mode_d = `PMS_MODE_FREE;
        endcase
        if (!init_done)
            mode_d = `PMS_MODE_FREE;
    end

    always @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            mode_q <= `PMS_MODE_FREE;
            lock_cnt_q <= 32'h0;
            hist_cnt_q <= 64'h0;
        end
        else
        begin
            mode_q <= mode_d;
            if (mode_q == `PMS_MODE_ACQ && sel_valid && lk_s2_q)
                lock_cnt_q <= lock_cnt_q + 32'h1;
            else
                lock_cnt_q <= 32'h0;
            // History counts locked time up to its 120 s window; cleared only by reinit
            if (!init_done)
                hist_cnt_q <= 64'h0;
            else if (mode_q == `PMS_MODE_LOCKED && hist_cnt_q < HIST_W)
                hist_cnt_q <= hist_cnt_q + 64'h1;
        end
    end

    assign MODE = mode_q;
    assign LOCK_LOSS_INDICATOR = (mode_q != `PMS_MODE_LOCKED);
    assign ACTIVE_BW = (fast_en_q && mode_q == `PMS_MODE_ACQ) ? bw_q[7:4] : bw_q[3:0];

    ////////////////////////////////////////////////////////////////////////
    // Read port
    always @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            RDATA <= 32'h0;
        else if (rd_ok)
        begin
            case (ADDR)
                `PMS_REG_CTRL: RDATA <= {29'h0, fast_en_q, 2'h0};
                `PMS_REG_STATUS:
                    RDATA <= {26'h0, hist_valid, init_done, !LOCK_LOSS_INDICATOR, mode_q};
                `PMS_REG_BW: RDATA <= {24'h0, bw_pend_q};
                `PMS_REG_INSEL: RDATA <= {28'h0, insel_pend_q};
                `PMS_REG_PLAN: RDATA <= plan_pend_q;
                `PMS_REG_STORE: RDATA <= {31'h0, store_req_q};
                default: RDATA <= 32'h0;
            endcase
        end
        else
            RDATA <= 32'h0;
    end
endmodule
`default_nettype wire

//--- verif/pms_top_chk.sv
`include "pms_defs.vh"
`default_nettype none
module pms_top_chk (
    // Clock and resets
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic HARD_RESET_PIN_N,
    // Inputs watched
    input wire logic [3:0] CLK_VALID,
    input wire logic RD,
    // Outputs watched
    input wire logic [31:0] RDATA,
    input wire logic LOCK_LOSS_INDICATOR,
    input wire logic OUT_CLK_EN,
    input wire logic INIT_DONE,
    input wire logic [2:0] MODE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////////////////////////
    AST_LOL_MODE: assert property
        (LOCK_LOSS_INDICATOR == (MODE != `PMS_MODE_LOCKED)) else $error("lock pin off");
    AST_CLK_GATE: assert property
        ((!HARD_RESET_PIN_N)[*5] |-> !OUT_CLK_EN) else $error("clocks during reset");
    AST_INIT_REFUSE: assert property
        (!INIT_DONE && RD |=> RDATA == 32'h0) else $error("read taken in init");
    AST_RD_IDLE: assert property
        (!RD |=> RDATA == 32'h0) else $error("read data without read");
    AST_MODE_RANGE: assert property
        (MODE <= `PMS_MODE_HOLD) else $error("illegal mode");
    AST_FREE_STAY: assert property
        ((CLK_VALID == 4'h0)[*4] ##0 MODE == `PMS_MODE_FREE |=> MODE == `PMS_MODE_FREE)
        else $error("left free-run");
    AST_ACQ_START: assert property
        (INIT_DONE && MODE == `PMS_MODE_FREE && CLK_VALID != 4'h0
        |-> ##[1:6] MODE == `PMS_MODE_ACQ) else $error("no acquisition");
    AST_HOLD_ENTRY: assert property
        (MODE == `PMS_MODE_LOCKED && CLK_VALID == 4'h0 |-> ##[1:6] MODE == `PMS_MODE_HOLD)
        else $error("no holdover");
    AST_REACQ: assert property
        ((MODE == `PMS_MODE_HOLD || MODE == `PMS_MODE_FREEZE) && CLK_VALID != 4'h0
        |-> ##[1:6] MODE == `PMS_MODE_ACQ) else $error("no reacquisition");
    AST_INIT_FREE: assert property
        ($rose(INIT_DONE) |-> MODE == `PMS_MODE_FREE) else $error("init not free-run");
    AST_HARD_PIN: assert property
        ((!HARD_RESET_PIN_N)[*5] |-> !INIT_DONE) else $error("pin reset ignored");
    AST_INIT_BOUND: assert property
        (!INIT_DONE |-> ##[1:30] INIT_DONE) else $error("init too long");
endmodule
bind pms_top pms_top_chk chk_u (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .HARD_RESET_PIN_N(HARD_RESET_PIN_N), .CLK_VALID(CLK_VALID), .RD(RD), .RDATA(RDATA),
    .LOCK_LOSS_INDICATOR(LOCK_LOSS_INDICATOR), .OUT_CLK_EN(OUT_CLK_EN),
    .INIT_DONE(INIT_DONE), .MODE(MODE));
`default_nettype wire

//--- verif/pms_src_model.sv
`default_nettype none
module pms_src_model (
    // Clock
    input wire logic clk,
    // Bench control
    input wire logic [3:0] want_valid,
    input wire logic lock_ok,
    // Toward the sequencer
    output logic [3:0] clk_valid = 4'h0,
    output logic phase_locked = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int settle = 0;
    // Detector claims lock only after settling, never the cycle a clock shows up
    always @(posedge clk)
    begin
        clk_valid <= want_valid;
        if (want_valid == 4'h0 || !lock_ok)
            settle <= 0;
        else if (settle < 6)
            settle <= settle + 1;
        phase_locked <= (settle == 6);
    end
endmodule
`default_nettype wire

//--- verif/tb_pms_top.sv
`include "pms_defs.vh"
`default_nettype none
module tb_pms_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hard_n = 1'b1;
    logic [3:0] want = 4'h0;
    logic lock_ok = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    wire [3:0] clk_valid;
    wire phase_locked;
    wire lock_loss_indicator;
    wire clk_en;
    wire init_done;
    wire [31:0] rdata;
    wire [31:0] plan;
    wire [2:0] mode;
    wire [3:0] active_bw;
    wire [1:0] active_input;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    pms_src_model src_u (.clk(ref_clk), .want_valid(want), .lock_ok(lock_ok),
        .clk_valid(clk_valid), .phase_locked(phase_locked));
    // Short history and lock counts keep the run brief
    pms_top #(.HIST_CYCLES(1000), .LOCK_CYCLES(4)) dut_u (.REF_CLK(ref_clk),
        .RESET_N(reset_n), .HARD_RESET_PIN_N(hard_n), .CLK_VALID(clk_valid),
        .PHASE_LOCKED(phase_locked), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .LOCK_LOSS_INDICATOR(lock_loss_indicator), .OUT_CLK_EN(clk_en), .INIT_DONE(init_done),
        .MODE(mode), .ACTIVE_BW(active_bw), .ACTIVE_INPUT(active_input), .PLAN(plan));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk);
        wr_s <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge ref_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk);
        rd_s <= 1'b0;
        @(negedge ref_clk);
        chk(n, e, rdata);
    endtask
    task automatic wait_init;
        repeat (4) @(negedge ref_clk);
        for (int i = 0; i < 60 && init_done !== 1'b1; i++)
            @(negedge ref_clk);
        chk("init done", 1, init_done);
    endtask
    task automatic wait_mode(input logic [2:0] m);
        for (int i = 0; i < 60 && mode !== m; i++)
            @(negedge ref_clk);
        chk("mode", m, mode);
    endtask
    task automatic pin_reset;
        @(posedge ref_clk);
        hard_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        hard_n <= 1'b1;
        wait_init();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            results();
        end
    end
    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        chk("clock enable", 0, clk_en);
        chk("lock loss", 1, lock_loss_indicator);
        reg_rd(`PMS_REG_STATUS, 0, "early status");
        wait_init();
        chk("clock enable", 1, clk_en);
        chk("mode", `PMS_MODE_FREE, mode);
        reg_rd(`PMS_REG_STATUS, 32'h10, "status");
        reg_rd(8'h20, 0, "unmapped");
        reg_wr(`PMS_REG_BW, 32'hf0);
        reg_wr(`PMS_REG_INSEL, 32'h4);
        reg_wr(`PMS_REG_PLAN, 32'h1234abcd);
        reg_wr(`PMS_REG_CTRL, 32'h6);
        wait_init();
        chk("plan", 32'h1234abcd, plan);
        reg_rd(`PMS_REG_BW, 32'hf0, "bandwidth");
        reg_rd(`PMS_REG_CTRL, 32'h4, "control");
        reg_wr(`PMS_REG_STORE, 32'h1);
        // Store shows no completion flag at the ports, so allow it time
        repeat (12) @(posedge ref_clk);
        for (int k = 0; k < 2; k++)
        begin
            reg_wr(`PMS_REG_PLAN, 32'h0);
            reg_wr(`PMS_REG_CTRL, 32'h2);
            wait_init();
            chk("pending plan", 32'h0, plan);
            if (k == 0)
                pin_reset();
            else
            begin
                reg_wr(`PMS_REG_CTRL, 32'h1);
                wait_init();
            end
            chk("reloaded plan", 32'h1234abcd, plan);
            reg_rd(`PMS_REG_BW, 32'hf0, "reloaded bandwidth");
        end
        reg_wr(`PMS_REG_CTRL, 32'h4);
        @(posedge ref_clk) want <= 4'h2;
        wait_mode(`PMS_MODE_ACQ);
        chk("clock enable", 1, clk_en);
        chk("fast bandwidth", 4'hf, active_bw);
        chk("auto input", 1, active_input);
        @(posedge ref_clk) lock_ok <= 1'b1;
        wait_mode(`PMS_MODE_LOCKED);
        chk("normal bandwidth", 4'h0, active_bw);
        chk("lock loss", 0, lock_loss_indicator);
        reg_rd(`PMS_REG_STATUS, 32'h3b, "locked status");
        @(posedge ref_clk) want <= 4'h0;
        wait_mode(`PMS_MODE_HOLD);
        @(posedge ref_clk) want <= 4'h8;
        wait_mode(`PMS_MODE_ACQ);
        chk("auto input", 3, active_input);
        @(posedge ref_clk) want <= 4'h0;
        lock_ok <= 1'b0;
        wait_mode(`PMS_MODE_HOLD);
        pin_reset();
        reg_rd(`PMS_REG_CTRL, 0, "control after reset");
        reg_wr(`PMS_REG_INSEL, 32'h2);
        reg_wr(`PMS_REG_CTRL, 32'h2);
        wait_init();
        @(posedge ref_clk) want <= 4'h5;
        wait_mode(`PMS_MODE_ACQ);
        chk("manual input", 2, active_input);
        chk("slow bandwidth", 4'h0, active_bw);
        @(posedge ref_clk) want <= 4'h0;
        wait_mode(`PMS_MODE_FREEZE);
        results();
    end
endmodule
`default_nettype wire
